// ===== logic/pcicfg_header.sv
// configuration header slice: command, status, stepping, class code, cache line size
// assumes a config port that presents one dword access per cycle with byte enables
// Behaviour
// - interrupt disable blocks pin interrupt, not messages
// - fast back-to-back only while enable set
// - serr driven only while enable set
// - parity response enable drives perr on error
// - write-invalidate only while its enable set
// - bits 15:11,7,5,3 of command read zero
// - bus master clear halts all dma ports
// - memory decode enable gates register space claims
// - io decode enable gates io space
// - parity error sets detected parity flag
// - driving serr sets signaled system error
// - own cycle aborts set received abort flags
// - target abort by us sets signaled flag
// - master parity fault only with parity response
// - timing, b2b, 66MHz capability fields read-only constants
// - capabilities list bit reads one
// - interrupt status reads live interrupt state
// - stepping byte read-only eight bits
// - class code storage, sata, ahci one
// - raid option switches subclass and interface
// - cache line size writable, resets zero
`timescale 1ns/1ps
module pcicfg_header #(
  parameter logic [7:0] STEPPING = 8'h5A, // arbitrary value
  parameter bit RAID_MODE = 1'b0,
  parameter bit IO_DECODE_RW = 1'b0,
  parameter bit B2B_RW = 1'b1,
  parameter bit MWI_RW = 1'b1,
  parameter bit B2B_CAPABLE = 1'b0,
  parameter bit HIGH_SPEED = 1'b0,
  parameter int NUM_PORTS = 4
) (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic CFG_RD_I,
  input wire logic CFG_WR_I,
  input wire logic [5:0] CFG_DWORD_I,
  input wire logic [3:0] CFG_BE_I,
  input wire logic [31:0] CFG_WDATA_I,
  input wire logic [NUM_PORTS-1:0] PORT_RUN_I,
  input wire logic IRQ_REQ_I,
  input wire logic MSI_EN_I,
  input wire logic PARITY_ERR_I,
  input wire logic MASTER_CYCLE_I,
  input wire logic PERR_SEEN_I,
  input wire logic SERR_EVENT_I,
  input wire logic MST_ABORT_I,
  input wire logic TGT_ABORT_RCV_I,
  input wire logic TGT_ABORT_SIG_I,
  input wire logic MEM_HIT_I,
  input wire logic IO_HIT_I,
  output logic [31:0] CFG_RDATA_O,
  output logic CFG_ACK_O,
  output logic INTX_O,
  output logic PERR_DRIVE_O,
  output logic SERR_DRIVE_O,
  output logic MASTER_EN_O,
  output logic [NUM_PORTS-1:0] PORT_RUN_O,
  output logic B2B_EN_O,
  output logic MWI_EN_O,
  output logic [7:0] CACHE_LINE_O,
  output logic MEM_CLAIM_O,
  output logic IO_CLAIM_O
);
  import pcicfg_pkg::*;

  // ****************
  // parameter checks
  // ****************
  // one run bit per port engine, and a controller has at most 32 of them
  if (NUM_PORTS < 1 || NUM_PORTS > 32) begin : g_bad_ports
    $error("NUM_PORTS must be 1 to 32");
  end

  // ****************
  // state
  // ****************
  typedef struct packed {
    logic [15:0] cmd;
    logic [7:0] cache_line_length;
    logic [31:0] rdata;
    logic ack;
    logic intx;
    logic perr;
    logic serr;
    logic master;
    logic [NUM_PORTS-1:0] run;
    logic b2b;
    logic mwi;
    logic mem_claim;
    logic io_claim;
  } pcicfg_state_t;
  pcicfg_state_t st_q, st_d;

  // a read-only enable keeps its reset value because its mask bit stays clear
  localparam logic [15:0] CMD_RW_MASK = (CMD_RW_MASK_BASE
    | (IO_DECODE_RW ? 16'h0001 : 16'h0000)
    | (MWI_RW ? 16'h0010 : 16'h0000))
    & (B2B_RW ? 16'hFFFF : 16'hFDFF);
  localparam logic [7:0] SUBCLASS = RAID_MODE ? SUBCLASS_RAID : SUBCLASS_SERIAL;
  localparam logic [7:0] PROGIF = RAID_MODE ? PROGIF_RAID : PROGIF_AHCI1;

  logic [5:0] flag_set, flag_clr, flags;
  logic perr_drv, serr_drv;
  logic [15:0] sts_word;
  logic cmd_sel, cls_sel;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] be, input logic [15:0] mask);
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge16 = (old & ~lane) | (nw & lane);
  endfunction : merge16

  // ****************
  // status word
  // ****************
  assign cmd_sel = CFG_WR_I && (CFG_DWORD_I == DW_CMD_STS);
  assign cls_sel = CFG_WR_I && (CFG_DWORD_I == DW_CLS);
  // write one clears; only byte lanes that are enabled
  assign flag_clr = cmd_sel ? {CFG_WDATA_I[16+STS_PARITY_SEEN] & CFG_BE_I[3],
                               CFG_WDATA_I[16+STS_SYSERR_RAISED] & CFG_BE_I[3],
                               CFG_WDATA_I[16+STS_MST_ABORT_RCV] & CFG_BE_I[3],
                               CFG_WDATA_I[16+STS_TGT_ABORT_RCV] & CFG_BE_I[3],
                               CFG_WDATA_I[16+STS_TGT_ABORT_SIG] & CFG_BE_I[3],
                               CFG_WDATA_I[16+STS_MASTER_PARITY] & CFG_BE_I[3]} : 6'h00;

  pcicfg_abort_track u_track (
    .clk_i(CORE_CLK_I),
    .srst_i(SRST_I),
    .parity_resp_i(st_q.cmd[CMD_PARITY_RESP]),
    .syserr_en_i(st_q.cmd[CMD_SYSERR]),
    .parity_err_i(PARITY_ERR_I),
    .master_cycle_i(MASTER_CYCLE_I),
    .perr_seen_i(PERR_SEEN_I),
    .serr_event_i(SERR_EVENT_I),
    .mst_abort_i(MST_ABORT_I),
    .tgt_abort_rcv_i(TGT_ABORT_RCV_I),
    .tgt_abort_sig_i(TGT_ABORT_SIG_I),
    .set_o(flag_set),
    .perr_drive_o(perr_drv),
    .serr_drive_o(serr_drv)
  );

  pcicfg_status_flags u_flags (
    .clk_i(CORE_CLK_I),
    .srst_i(SRST_I),
    .set_i(flag_set),
    .clr_i(flag_clr),
    .flags_o(flags)
  );

  always_comb begin
    sts_word = 16'h0000;
    sts_word[STS_PARITY_SEEN] = flags[5];
    sts_word[STS_SYSERR_RAISED] = flags[4];
    sts_word[STS_MST_ABORT_RCV] = flags[3];
    sts_word[STS_TGT_ABORT_RCV] = flags[2];
    sts_word[STS_TGT_ABORT_SIG] = flags[1];
    sts_word[STS_MASTER_PARITY] = flags[0];
    sts_word[STS_SEL_TIMING_LO +: 2] = SEL_TIMING_DEFAULT;
    sts_word[STS_B2B_CAPABLE] = B2B_CAPABLE;
    sts_word[STS_HIGH_SPEED] = HIGH_SPEED;
    sts_word[STS_CAP_CHAIN] = 1'b1;
    sts_word[STS_IRQ_PENDING] = IRQ_REQ_I;
  end

  // ****************
  // register and control logic
  // ****************
  always_comb begin
    st_d = st_q;
    st_d.ack = CFG_RD_I | CFG_WR_I;
    if (cmd_sel) begin
      st_d.cmd = merge16(st_q.cmd, CFG_WDATA_I[15:0], CFG_BE_I[1:0], CMD_RW_MASK);
    end
    if (cls_sel && CFG_BE_I[0]) begin
      st_d.cache_line_length = CFG_WDATA_I[7:0];
    end
    st_d.rdata = 32'h0000_0000;
    if (CFG_RD_I) begin
      unique case (CFG_DWORD_I)
        DW_CMD_STS: st_d.rdata = {sts_word, st_q.cmd};
        DW_REV_CLASS: st_d.rdata = {BASE_CLASS_STORAGE, SUBCLASS, PROGIF, STEPPING};
        DW_CLS: st_d.rdata = {24'h000000, st_q.cache_line_length};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
    // legacy pin is held off by the disable bit or when messages carry interrupts
    st_d.intx = IRQ_REQ_I & ~st_q.cmd[CMD_IRQ_BLOCK] & ~MSI_EN_I;
    st_d.perr = perr_drv;
    st_d.serr = serr_drv;
    st_d.master = st_q.cmd[CMD_BUS_MASTER];
    // a cleared master enable forces every port engine back to idle
    st_d.run = st_q.cmd[CMD_BUS_MASTER] ? PORT_RUN_I : '0;
    st_d.b2b = st_q.cmd[CMD_BACK_TO_BACK];
    st_d.mwi = st_q.cmd[CMD_WRITE_INVAL] & (st_q.cache_line_length != 8'h00);
    st_d.mem_claim = MEM_HIT_I & st_q.cmd[CMD_MEM_DECODE];
    st_d.io_claim = IO_HIT_I & st_q.cmd[CMD_IO_DECODE];
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      st_q <= '0;
      st_q.cmd <= CMD_RESET;
      st_q.cache_line_length <= CLS_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************
  // outputs
  // ****************
  assign CFG_RDATA_O = st_q.rdata;
  assign CFG_ACK_O = st_q.ack;
  assign INTX_O = st_q.intx;
  assign PERR_DRIVE_O = st_q.perr;
  assign SERR_DRIVE_O = st_q.serr;
  assign MASTER_EN_O = st_q.master;
  assign PORT_RUN_O = st_q.run;
  assign B2B_EN_O = st_q.b2b;
  assign MWI_EN_O = st_q.mwi;
  assign CACHE_LINE_O = st_q.cache_line_length;
  assign MEM_CLAIM_O = st_q.mem_claim;
  assign IO_CLAIM_O = st_q.io_claim;

  // ****************
  // checks
  // ****************
  chk_irq_blocked: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    $past(st_q.cmd[CMD_IRQ_BLOCK]) |-> !INTX_O)
    else $error("pin interrupt while blocked");
  chk_intx_msi: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    $past(MSI_EN_I) |-> !INTX_O)
    else $error("pin interrupt while messages in use");
  chk_intx_follows: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (!$past(SRST_I) && $past(IRQ_REQ_I) && !$past(st_q.cmd[CMD_IRQ_BLOCK]) && !$past(MSI_EN_I)) |-> INTX_O)
    else $error("pin interrupt missing");
  chk_b2b_gate: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    B2B_EN_O |-> $past(st_q.cmd[CMD_BACK_TO_BACK]))
    else $error("back to back without enable");
  // the drive requests pass two registers, so the enable is looked up two edges back
  chk_serr_needs_en: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    SERR_DRIVE_O |-> $past(st_q.cmd[CMD_SYSERR], 2))
    else $error("serr driven while disabled");
  chk_perr_needs_en: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    PERR_DRIVE_O |-> $past(st_q.cmd[CMD_PARITY_RESP], 2))
    else $error("perr driven while disabled");
  chk_mwi_gate: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    MWI_EN_O |-> $past(st_q.cmd[CMD_WRITE_INVAL]))
    else $error("write invalidate without enable");
  chk_mwi_cls: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    MWI_EN_O |-> $past(CACHE_LINE_O) != 8'h00)
    else $error("write invalidate without line size");
  chk_reserved_zero: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (st_q.cmd & 16'hF8A8) == 16'h0000)
    else $error("reserved command bit set");
  chk_reserved_read: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (CFG_RD_I && CFG_DWORD_I == DW_CMD_STS) |=> (CFG_RDATA_O & 32'h0047_F8A8) == 32'h0000_0000)
    else $error("reserved bit read as one");
  chk_master_halt: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    !st_q.cmd[CMD_BUS_MASTER] |=> PORT_RUN_O == '0)
    else $error("port running without master enable");
  chk_run_gated: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (PORT_RUN_O != '0) |-> MASTER_EN_O)
    else $error("port running while master output low");
  chk_mem_claim: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    MEM_CLAIM_O |-> $past(st_q.cmd[CMD_MEM_DECODE]) && $past(MEM_HIT_I))
    else $error("memory claimed while disabled");
  chk_io_claim: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    IO_CLAIM_O |-> $past(st_q.cmd[CMD_IO_DECODE]))
    else $error("io claimed while disabled");
  chk_io_fixed: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    st_q.cmd[CMD_IO_DECODE] |-> IO_DECODE_RW)
    else $error("read-only io enable was written");
  chk_serr_flag: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    SERR_DRIVE_O |=> flags[4])
    else $error("serr not recorded");
  chk_status_read: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (CFG_RD_I && CFG_DWORD_I == DW_CMD_STS) |=> CFG_RDATA_O[16+STS_CAP_CHAIN]
      && CFG_RDATA_O[16+STS_SEL_TIMING_LO +: 2] == SEL_TIMING_DEFAULT
      && CFG_RDATA_O[16+STS_B2B_CAPABLE] == B2B_CAPABLE
      && CFG_RDATA_O[16+STS_HIGH_SPEED] == HIGH_SPEED)
    else $error("status constant field wrong");
  chk_irq_status: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (CFG_RD_I && CFG_DWORD_I == DW_CMD_STS) |=> CFG_RDATA_O[16+STS_IRQ_PENDING] == $past(IRQ_REQ_I))
    else $error("interrupt status wrong");
  chk_class_read: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (CFG_RD_I && CFG_DWORD_I == DW_REV_CLASS) |=> CFG_RDATA_O[31:24] == 8'h01)
    else $error("base class wrong");
  chk_cls_write: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (cls_sel && CFG_BE_I[0]) |=> CACHE_LINE_O == $past(CFG_WDATA_I[7:0]))
    else $error("cache line size not written");
  chk_cls_hold: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    !(cls_sel && CFG_BE_I[0]) |=> CACHE_LINE_O == $past(CACHE_LINE_O))
    else $error("cache line size changed without write");

  // ****************
  // cover points
  // ****************
  cov_cmd_write: cover property (@(posedge CORE_CLK_I) cmd_sel ##1 CFG_ACK_O);
  cov_flag_clear: cover property (@(posedge CORE_CLK_I) flags[3] ##1 !flags[3]);
  cov_master_off: cover property (@(posedge CORE_CLK_I) MASTER_EN_O ##1 !MASTER_EN_O);
  cov_serr_drive: cover property (@(posedge CORE_CLK_I) SERR_DRIVE_O);
  cov_intx_drop: cover property (@(posedge CORE_CLK_I) INTX_O ##1 !INTX_O);
endmodule : pcicfg_header

// ===== common/pcicfg_pkg.sv
// pci configuration header slice: offsets, field positions, reset values
// assumes a dword-wide configuration access port with byte enables
package pcicfg_pkg;
  // ****************
  // register offsets (byte addresses within config space; the DW_ values are dword indices)
  // ****************
  localparam logic [7:0] OFF_COMMAND_WORD = 8'h04;
  localparam logic [7:0] OFF_STATUS_WORD = 8'h06;
  localparam logic [7:0] OFF_STEPPING_BYTE = 8'h08;
  localparam logic [7:0] OFF_CLASS_CODE_TRIPLET = 8'h09;
  localparam logic [7:0] OFF_CACHE_LINE_LENGTH = 8'h0C;
  localparam logic [5:0] DW_CMD_STS = 6'h01;
  localparam logic [5:0] DW_REV_CLASS = 6'h02;
  localparam logic [5:0] DW_CLS = 6'h03;
  // ****************
  // command word bits
  // ****************
  localparam int CMD_IO_DECODE = 0;
  localparam int CMD_MEM_DECODE = 1;
  localparam int CMD_BUS_MASTER = 2;
  localparam int CMD_WRITE_INVAL = 4;
  localparam int CMD_PARITY_RESP = 6;
  localparam int CMD_SYSERR = 8;
  localparam int CMD_BACK_TO_BACK = 9;
  localparam int CMD_IRQ_BLOCK = 10;
  // ****************
  // status word bits
  // ****************
  localparam int STS_IRQ_PENDING = 3;
  localparam int STS_CAP_CHAIN = 4;
  localparam int STS_HIGH_SPEED = 5;
  localparam int STS_B2B_CAPABLE = 7;
  localparam int STS_MASTER_PARITY = 8;
  localparam int STS_SEL_TIMING_LO = 9;
  localparam int STS_TGT_ABORT_SIG = 11;
  localparam int STS_TGT_ABORT_RCV = 12;
  localparam int STS_MST_ABORT_RCV = 13;
  localparam int STS_SYSERR_RAISED = 14;
  localparam int STS_PARITY_SEEN = 15;
  localparam logic [15:0] STS_W1C_MASK = 16'hF900;
  // ****************
  // reset values, command write mask and fixed read values
  // ****************
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] CMD_RW_MASK_BASE = 16'h0746;
  localparam logic [7:0] BASE_CLASS_STORAGE = 8'h01;
  localparam logic [7:0] SUBCLASS_SERIAL = 8'h06;
  localparam logic [7:0] SUBCLASS_RAID = 8'h04;
  localparam logic [7:0] PROGIF_AHCI1 = 8'h01;
  localparam logic [7:0] PROGIF_RAID = 8'h00;
  localparam logic [7:0] CLS_RESET = 8'h00;
  localparam logic [1:0] SEL_TIMING_DEFAULT = 2'h1;
endpackage : pcicfg_pkg

// ===== logic/pcicfg_status_flags.sv
// sticky write-one-to-clear status error flags
// assumes event pulses are on the core clock and already qualified
`timescale 1ns/1ps
module pcicfg_status_flags (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [5:0] set_i,
  input wire logic [5:0] clr_i,
  output logic [5:0] flags_o
);
  import pcicfg_pkg::*;
  typedef struct packed {
    logic [5:0] flags;
  } pcicfg_flags_t;
  pcicfg_flags_t st_q, st_d;
  // set beats clear so an event in the clearing cycle is kept
  always_comb begin
    st_d = st_q;
    st_d.flags = (st_q.flags & ~clr_i) | set_i;
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign flags_o = st_q.flags;
  chk_set_wins: assert property (@(posedge clk_i) disable iff (srst_i)
    (set_i != 6'h00) |=> ((flags_o & $past(set_i)) == $past(set_i)))
    else $error("flag event lost");
  chk_zero_keeps: assert property (@(posedge clk_i) disable iff (srst_i)
    (clr_i == 6'h00 && set_i == 6'h00) |=> flags_o == $past(flags_o))
    else $error("flag changed without cause");
endmodule : pcicfg_status_flags

// ===== logic/pcicfg_abort_track.sv
// turns bus events into flag set pulses and the serr/perr drive requests
// assumes events are single-cycle pulses from the bus interface on the core clock
`timescale 1ns/1ps
module pcicfg_abort_track (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic parity_resp_i,
  input wire logic syserr_en_i,
  input wire logic parity_err_i,
  input wire logic master_cycle_i,
  input wire logic perr_seen_i,
  input wire logic serr_event_i,
  input wire logic mst_abort_i,
  input wire logic tgt_abort_rcv_i,
  input wire logic tgt_abort_sig_i,
  output logic [5:0] set_o,
  output logic perr_drive_o,
  output logic serr_drive_o
);
  import pcicfg_pkg::*;
  typedef struct packed {
    logic perr;
    logic serr;
  } pcicfg_drv_t;
  pcicfg_drv_t st_q, st_d;
  logic serr_now;
  always_comb begin
    st_d = st_q;
    st_d.perr = parity_err_i & parity_resp_i;
    st_d.serr = serr_event_i & syserr_en_i;
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign serr_now = st_q.serr;
  // index order: 0 master parity, 1 tgt abort sig, 2 tgt abort rcv, 3 mst abort, 4 syserr, 5 parity seen
  assign set_o[0] = master_cycle_i & (parity_err_i | perr_seen_i) & parity_resp_i;
  assign set_o[1] = tgt_abort_sig_i;
  assign set_o[2] = master_cycle_i & tgt_abort_rcv_i;
  assign set_o[3] = master_cycle_i & mst_abort_i;
  assign set_o[4] = serr_now;
  assign set_o[5] = parity_err_i;
  assign perr_drive_o = st_q.perr;
  assign serr_drive_o = st_q.serr;
  chk_serr_gated: assert property (@(posedge clk_i) disable iff (srst_i)
    serr_drive_o |-> $past(syserr_en_i) && $past(serr_event_i))
    else $error("serr without enable");
  chk_perr_follows: assert property (@(posedge clk_i) disable iff (srst_i)
    (parity_err_i && parity_resp_i) |=> perr_drive_o)
    else $error("perr not driven");
endmodule : pcicfg_abort_track

// ===== verification/pcicfg_host_model.sv
// host bridge model: issues single dword config reads and writes
// assumes the device answers with a one-cycle ack one cycle after each strobe
`timescale 1ns/1ps
module pcicfg_host_model (
  input wire logic clk_i,
  input wire logic [31:0] cfg_rdata_i,
  input wire logic cfg_ack_i,
  output logic cfg_rd_o,
  output logic cfg_wr_o,
  output logic [5:0] cfg_dword_o,
  output logic [3:0] cfg_be_o,
  output logic [31:0] cfg_wdata_o
);
  initial begin
    cfg_rd_o = 1'b0;
    cfg_wr_o = 1'b0;
    cfg_dword_o = 6'h00;
    cfg_be_o = 4'h0;
    cfg_wdata_o = 32'h00000000;
  end
  // ****************
  // one access
  // ****************
  // strobes drop low and the other released lines carry the inverse of the last value so stale data never looks valid
  task automatic access(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    int n;
    @(posedge clk_i);
    #2;
    cfg_rd_o = !wr;
    cfg_wr_o = wr;
    cfg_dword_o = dw;
    cfg_be_o = be;
    cfg_wdata_o = wd;
    @(posedge clk_i);
    #2;
    cfg_rd_o = 1'b0;
    cfg_wr_o = 1'b0;
    cfg_dword_o = ~dw;
    cfg_be_o = ~be;
    cfg_wdata_o = ~wd;
    ok = 1'b0;
    rd = 32'h00000000;
    for (n = 0; n < 4; n++) begin
      if (cfg_ack_i === 1'b1) begin
        ok = 1'b1;
        rd = cfg_rdata_i;
        break;
      end
      @(posedge clk_i);
      #2;
    end
  endtask : access
endmodule : pcicfg_host_model

// ===== verification/tb_top.sv
// testbench for the config header slice: register table, gates, status flags
// assumes the host model drives the config port and the bench drives bus events
`timescale 1ns/1ps
module tb_top;
  import pcicfg_pkg::*;
  typedef struct packed {logic [5:0] dw; logic [3:0] be; logic [31:0] wd; logic [31:0] exp;} pcicfg_row_t;
  localparam logic [15:0] STS_BASE = 16'h0210;
  localparam pcicfg_row_t ROWS [10] = '{
    '{DW_CMD_STS, 4'h0, 32'hFFFFFFFF, {STS_BASE, 16'h0000}},
    '{DW_CLS, 4'h0, 32'hFFFFFFFF, 32'h00000000},
    '{DW_CMD_STS, 4'h3, 32'h0000FFFF, {STS_BASE, 16'h0756}},
    '{DW_CMD_STS, 4'h3, 32'h00000000, {STS_BASE, 16'h0000}},
    '{DW_REV_CLASS, 4'hF, 32'hFFFFFFFF, {8'h01, SUBCLASS_SERIAL, PROGIF_AHCI1, 8'h3C}},
    '{DW_CLS, 4'h1, 32'h000000A5, 32'h000000A5},
    '{DW_CLS, 4'h2, 32'h0000FF00, 32'h000000A5},
    '{6'h00, 4'hF, 32'hFFFFFFFF, 32'h00000000},
    '{DW_CMD_STS, 4'h1, 32'h000000FF, {STS_BASE, 16'h0056}},
    '{DW_CMD_STS, 4'h2, 32'h0000FF00, {STS_BASE, 16'h0756}}};
  // events: {tgt_sig, tgt_rcv, mst_abort, serr_event, perr_seen, parity_err}; row 1 = gates on
  localparam logic [7:0] FLAGS [2][6] = '{'{8'h80, 8'h00, 8'h00, 8'h20, 8'h10, 8'h08},
                                          '{8'h81, 8'h01, 8'h40, 8'h20, 8'h10, 8'h08}};
  logic clk, srst, rd, wr, irq, msi, master, ack, mem_hit, io_hit, ok;
  logic intx, perr_drv, serr_drv, men, b2b, mwi, mclaim, iclaim;
  logic [5:0] dw, ev;
  logic [3:0] be, run_i, run_o;
  logic [31:0] wd, rdata, got;
  logic [7:0] cache_line_length;
  int n_errors, checks_done;
  pcicfg_header #(.STEPPING(8'h3C)) u_dut (  // stepping value is arbitrary
    .CORE_CLK_I(clk), .SRST_I(srst), .CFG_RD_I(rd), .CFG_WR_I(wr), .CFG_DWORD_I(dw), .CFG_BE_I(be),
    .CFG_WDATA_I(wd), .PORT_RUN_I(run_i), .IRQ_REQ_I(irq), .MSI_EN_I(msi), .PARITY_ERR_I(ev[0]),
    .MASTER_CYCLE_I(master), .PERR_SEEN_I(ev[1]), .SERR_EVENT_I(ev[2]), .MST_ABORT_I(ev[3]),
    .TGT_ABORT_RCV_I(ev[4]), .TGT_ABORT_SIG_I(ev[5]), .MEM_HIT_I(mem_hit), .IO_HIT_I(io_hit),
    .CFG_RDATA_O(rdata), .CFG_ACK_O(ack), .INTX_O(intx), .PERR_DRIVE_O(perr_drv), .SERR_DRIVE_O(serr_drv),
    .MASTER_EN_O(men), .PORT_RUN_O(run_o), .B2B_EN_O(b2b), .MWI_EN_O(mwi), .CACHE_LINE_O(cache_line_length),
    .MEM_CLAIM_O(mclaim), .IO_CLAIM_O(iclaim));
  pcicfg_host_model u_host (.clk_i(clk), .cfg_rdata_i(rdata), .cfg_ack_i(ack), .cfg_rd_o(rd), .cfg_wr_o(wr),
    .cfg_dword_o(dw), .cfg_be_o(be), .cfg_wdata_o(wd));
  // ****************
  // shared tasks
  // ****************
  task automatic wrap_up();
    $display("mismatches %0d of %0d checks", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk
  // a missing ack ends the run rather than leaving later checks out of step
  task automatic cfg(input logic w, input logic [5:0] d, input logic [3:0] b, input logic [31:0] v);
    u_host.access(w, d, b, v, got, ok);
    if (ok !== 1'b1) begin
      n_errors++;
      wrap_up();
    end
  endtask : cfg
  task automatic settle();
    repeat (2) @(posedge clk);
    #2;
  endtask : settle
  // the drive requests pass two registers, so they stand one edge after the event is dropped
  task automatic fire(input int i);
    @(posedge clk);
    #2;
    ev = 6'(1 << i);
    @(posedge clk);
    #2;
    ev = 6'h00;
    @(posedge clk);
    #2;
  endtask : fire
  // ****************
  // stimulus
  // ****************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    srst = 1'b1;
    {irq, msi, mem_hit, io_hit} = 4'h0;
    master = 1'b1;
    ev = 6'h00;
    run_i = 4'hF;
    n_errors = 0;
    checks_done = 0;
    repeat (8) @(posedge clk);
    #2;
    srst = 1'b0;
    chk({men, run_o, perr_drv, serr_drv, intx, cache_line_length}, 32'h0);
    for (int i = 0; i < 10; i++) begin
      cfg(1'b1, ROWS[i].dw, ROWS[i].be, ROWS[i].wd);
      cfg(1'b0, ROWS[i].dw, 4'hF, 32'h0);
      chk(got, ROWS[i].exp);
    end
    {mem_hit, io_hit, irq} = 3'h7;
    settle();
    chk({men, b2b, mwi, cache_line_length}, {3'h7, 8'hA5});
    chk({mclaim, iclaim, intx, run_o}, {3'h4, 4'hF});
    cfg(1'b1, DW_CMD_STS, 4'h2, 32'h00000300);
    settle();
    chk(intx, 1'b1);
    cfg(1'b0, DW_CMD_STS, 4'hF, 32'h0);
    chk(got[19], 1'b1);
    msi = 1'b1;
    settle();
    chk(intx, 1'b0);
    msi = 1'b0;
    for (int g = 1; g >= 0; g--) begin
      for (int i = 0; i < 6; i++) begin
        fire(i);
        chk({perr_drv, serr_drv}, {g == 1 && i == 0, g == 1 && i == 2});
        cfg(1'b1, DW_CMD_STS, 4'h8, 32'h00000000);
        cfg(1'b0, DW_CMD_STS, 4'hF, 32'h0);
        chk(got[31:24], FLAGS[g][i] | 8'h02);
        cfg(1'b1, DW_CMD_STS, 4'h8, 32'hF9000000);
        cfg(1'b0, DW_CMD_STS, 4'hF, 32'h0);
        chk(got[31:24], 8'h02);
      end
      cfg(1'b1, DW_CMD_STS, 4'h3, 32'h00000006);
    end
    chk({b2b, mwi, men, run_o}, {3'h1, 4'hF});
    cfg(1'b1, DW_CMD_STS, 4'h1, 32'h00000002);
    settle();
    chk({men, run_o, mclaim}, {5'h00, 1'b1});
    irq = 1'b0;
    srst = 1'b1;
    settle();
    srst = 1'b0;
    cfg(1'b0, DW_CLS, 4'hF, 32'h0);
    chk(got, 32'h0);
    chk(32'(cache_line_length), 32'h0);
    cfg(1'b0, DW_CMD_STS, 4'hF, 32'h0);
    chk(got, {STS_BASE, 16'h0000});
    wrap_up();
  end
endmodule : tb_top
